// >>> bench/bmd_decoder_tb.sv
// self-checking bench for the banked data memory decoder
`timescale 1ns/100ps
module bmd_decoder_tb;
	import bmd_pkg::*;
	logic        i_clock = 0, i_rst_b = 0, i_req = 0, i_wr = 0; // clock, reset, request
	bmd_mode_t   i_mode = BMD_MODE_NONE;                         // access kind
	bmd_off_t    i_offset = 7'h00;                               // direct offset
	bmd_byte_t   i_wdata = 8'h00, i_mem_rdata, o_rdata;          // data paths
	logic        o_mem_sel, o_mem_wr, o_core_hit, o_rvalid;      // design flags
	bmd_addr_t   o_mem_addr;                                     // array address
	bmd_bank_t   o_bank;                                         // bank selector
	bmd_region_t o_region;                                       // decoded region
	int          bank, core[12], mem[8192], expq[$];             // reference model
	int          bad_count, comparisons;                         // score
	logic [31:0] seed = 32'h6703B90F;                            // random source
	localparam bmd_mode_t D = BMD_MODE_DIRECT;
	always #20 i_clock = ~i_clock;
	bmd_decoder i_bmd_decoder (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_req(i_req),
		.i_wr(i_wr), .i_mode(i_mode), .i_offset(i_offset), .i_wdata(i_wdata),
		.i_mem_rdata(i_mem_rdata), .o_mem_sel(o_mem_sel), .o_mem_wr(o_mem_wr),
		.o_mem_addr(o_mem_addr), .o_region(o_region), .o_core_hit(o_core_hit),
		.o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_bank(o_bank));
	bmd_mem_model i_bmd_mem_model (.i_clock(i_clock), .i_sel(o_mem_sel), .i_wr(o_mem_wr),
		.i_addr(o_mem_addr), .i_wdata(i_wdata), .o_rdata(i_mem_rdata));
	// compare one value and count it
	task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// next value of the shift register
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	// step the shift register
	task automatic rnd;
		seed = lfsr_next(seed);
	endtask : rnd
	// one access: drive, check the decode, update the reference
	task automatic acc(input logic wr, input bmd_mode_t md, input int off, input int d);
		int a, o;
		@(negedge i_clock);
		i_req <= 1'b1;
		i_wr <= wr;
		i_mode <= md;
		i_offset <= off[6:0];
		i_wdata <= d[7:0];
		a = (md == D) ? bank * 128 + off : (md == BMD_MODE_PTR0) ?
			core[5] % 32 * 256 + core[4] : core[7] % 32 * 256 + core[6];
		o = a % 128;
		#1;
		chk(o_core_hit, o < 12);
		chk(o_mem_sel, o >= 12);
		chk(o_mem_wr, wr && o >= 12);
		if (o >= 12) chk(o_mem_addr, a);
		chk(o_region, o < 12 ? 0 : o < 32 ? 1 : o < 112 ? 2 : 3);
		if (o < 12) begin
			if (wr && o == 8) bank = d % 64;
			else if (wr && o > 1) core[o] = d % 256;
			if (!wr) expq.push_back(o < 2 ? 0 : o == 8 ? bank : core[o]);
		end else if (wr) mem[a] = d % 256;
		else expq.push_back(mem[a]);
	endtask : acc
	// cycles with the request dropped or with no access mode
	task automatic idle(input int n);
		for (int k = 0; k < n; k++) begin
			@(negedge i_clock);
			i_req <= k[0];
			i_mode <= BMD_MODE_NONE;
			#1;
			chk(o_mem_sel, 0);
			if (!i_req) chk(o_core_hit, 0);
			chk(o_bank, bank);
		end
	endtask : idle
	// every read answer in order
	always @(negedge i_clock) if (o_rvalid === 1'b1) begin
		if (expq.size() == 0) chk(1, 0);
		else chk(o_rdata, expq.pop_front());
	end
	// print counts and verdict
	task automatic wrap_up;
		chk(expq.size(), 0);
		$display("counts: comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	// cut a hang short
	initial begin
		#1000000;
		bad_count++;
		wrap_up;
	end
	// main sequence
	initial begin
		repeat (4) @(posedge i_clock);
		@(negedge i_clock) i_rst_b <= 1'b1;
		for (int k = 4; k < 11; k++) acc(0, D, k, 0);
		idle(2);
		$display("test reset values done");
		for (int n = 0; n < 4; n++) begin
			for (int k = 0; k < 12; k++) begin
				rnd;
				acc(1, D, k, seed[7:0]);
			end
			for (int k = 0; k < 12; k++) if (k != 2 && k != 3) acc(0, D, k, 0);
			idle(2);
		end
		$display("test core window done");
		acc(1, D, 8, 'hFF);
		acc(1, D, 127, 'h5A);
		acc(0, D, 127, 0);
		idle(2);
		for (int n = 0; n < 24; n++) begin
			rnd;
			acc(1, D, 8, seed[7:0]);
			acc(1, D, 12 + seed[15:8] % 116, seed[23:16]);
			acc(0, D, 12 + seed[15:8] % 116, 0);
			acc(0, D, 8, 0);
			idle(2);
		end
		$display("test bank switch done");
		for (int n = 0; n < 12; n++) begin
			for (int k = 4; k < 8; k++) begin
				rnd;
				acc(1, D, k, (n == 0 && k == 6) ? 8 : seed[7:0]);
			end
			acc(1, BMD_MODE_PTR1, 0, seed[15:8]);
			acc(1, BMD_MODE_PTR0, 0, seed[23:16]);
			acc(0, BMD_MODE_PTR1, 0, 0);
			idle(2);
			acc(0, BMD_MODE_PTR0, 0, 0);
			idle(2);
		end
		$display("test pointers done");
		@(negedge i_clock) i_rst_b <= 1'b0;
		bank = 0;
		foreach (core[k]) core[k] = 0;
		@(negedge i_clock) i_rst_b <= 1'b1;
		#1;
		chk(o_bank, 0);
		chk(o_rvalid, 0);
		for (int k = 2; k < 12; k++) acc(0, D, k, 0);
		idle(2);
		$display("test mid-run reset done");
		wrap_up;
	end
endmodule : bmd_decoder_tb

// >>> bench/bmd_mem_model.sv
// memory array model that answers the decoder one cycle after a read select
`timescale 1ns/100ps
module bmd_mem_model (
	input  wire logic        i_clock, // core clock
	input  wire logic        i_sel,   // array selected
	input  wire logic        i_wr,    // array write strobe
	input  wire logic [12:0] i_addr,  // array address
	input  wire logic [7:0]  i_wdata, // write data
	output logic      [7:0]  o_rdata  // read data, valid one cycle after a read
);
	logic [7:0] mem [64*128]; // every byte of every bank
	// start from a cleared array
	initial foreach (mem[k]) mem[k] = 8'h00;
	initial o_rdata = 8'h00;
	// store writes, answer reads, otherwise keep the bus changing
	always @(posedge i_clock) begin
		if (i_sel && i_wr) mem[i_addr] <= i_wdata;
		o_rdata <= (i_sel && !i_wr) ? mem[i_addr] : ~o_rdata;
	end
endmodule : bmd_mem_model

// >>> hw/bmd_decoder.sv
// banked data memory decoder with the twelve core registers
`timescale 1ns/100ps
`include "bmd_regs.svh"
module bmd_decoder (
	input  wire logic            i_clock,     // core clock
	input  wire logic            i_rst_b,     // async reset, active low
	input  wire logic            i_req,       // access request this cycle
	input  wire logic            i_wr,        // write when high, read when low
	input  wire bmd_pkg::bmd_mode_t i_mode,   // direct or pointer access
	input  wire bmd_pkg::bmd_off_t  i_offset, // in-bank offset for direct access
	input  wire bmd_pkg::bmd_byte_t i_wdata,  // write data
	input  wire bmd_pkg::bmd_byte_t i_mem_rdata, // data returned by the memory array
	output logic                 o_mem_sel,   // memory array selected (not core)
	output logic                 o_mem_wr,    // memory write strobe
	output bmd_pkg::bmd_addr_t   o_mem_addr,  // 13-bit memory address
	output bmd_pkg::bmd_region_t o_region,    // region of the decoded address
	output logic                 o_core_hit,  // request decodes to a core register, i_mode not checked (also with no access mode)
	output bmd_pkg::bmd_byte_t   o_rdata,     // read data, registered
	output logic                 o_rvalid,    // read data valid, one cycle
	output bmd_pkg::bmd_bank_t   o_bank       // current bank selector value
);
	import bmd_pkg::*;

	// whole state of the block
	typedef struct packed {
		bmd_byte_t program_counter_low;
		bmd_byte_t flags;
		bmd_byte_t p0l;
		bmd_byte_t p0h;
		bmd_byte_t p1l;
		bmd_byte_t p1h;
		bmd_bank_t bank;
		bmd_byte_t acc;
		bmd_byte_t pch;
		bmd_byte_t intc;
		bmd_byte_t rdata;
		logic      rvalid;
		logic      rd_mem;
		bmd_byte_t core_q;      // core read value held one cycle
		logic      rd_core;     // core read answers next cycle
	} bmd_state_t;

	bmd_state_t st_r;       // registered state
	bmd_state_t st_nxt;     // next state
	bmd_addr_t  addr;       // decoded address
	bmd_off_t   eff_off;    // effective in-bank offset
	logic       core_hit;   // address on a core register
	bmd_byte_t  core_rd;    // core register read value

	// address formation for all three access modes
	always_comb begin
		case (i_mode)
			BMD_MODE_PTR0: addr = {st_r.p0h[4:0], st_r.p0l};
			BMD_MODE_PTR1: addr = {st_r.p1h[4:0], st_r.p1l};
			default:       addr = {st_r.bank, i_offset};
		endcase
	end

	assign eff_off  = addr[`BMD_BANK_LSB-1:0];
	assign core_hit = (eff_off <= `BMD_CORE_LAST);

	// region split inside every bank
	always_comb begin
		if (eff_off <= `BMD_CORE_LAST) begin
			o_region = BMD_REGION_CORE;
		end else if (eff_off < `BMD_GPR_FIRST) begin
			o_region = BMD_REGION_SFR;
		end else if (eff_off < `BMD_COMMON_FIRST) begin
			o_region = BMD_REGION_GPR;
		end else begin
			o_region = BMD_REGION_COMMON;
		end
	end

	// core register read mux, same in every bank
	always_comb begin
		if (eff_off == `BMD_OFF_PCL) begin
			core_rd = st_r.program_counter_low;
		end else if (eff_off == `BMD_OFF_FLAGS) begin
			core_rd = st_r.flags;
		end else if (eff_off == `BMD_OFF_P0L) begin
			core_rd = st_r.p0l;
		end else if (eff_off == `BMD_OFF_P0H) begin
			core_rd = st_r.p0h;
		end else if (eff_off == `BMD_OFF_P1L) begin
			core_rd = st_r.p1l;
		end else if (eff_off == `BMD_OFF_P1H) begin
			core_rd = st_r.p1h;
		end else if (eff_off == `BMD_OFF_BANK) begin
			core_rd = {2'b00, st_r.bank};
		end else if (eff_off == `BMD_OFF_ACC) begin
			core_rd = st_r.acc;
		end else if (eff_off == `BMD_OFF_PCH) begin
			core_rd = st_r.pch;
		end else if (eff_off == `BMD_OFF_INTC) begin
			core_rd = st_r.intc;
		end else begin
			core_rd = `BMD_BYTE_RST;    // indirect windows read zero
		end
	end

	// next-state logic
	always_comb begin
		st_nxt        = st_r;
		st_nxt.rvalid = 1'b0;
		st_nxt.rd_mem = 1'b0;
		st_nxt.rd_core = 1'b0;
		if (st_r.rd_mem) begin
			st_nxt.rdata  = i_mem_rdata;    // capture array data
			st_nxt.rvalid = 1'b1;
		end else if (st_r.rd_core) begin
			// core reads wait one cycle so that they keep order behind array reads
			st_nxt.rdata  = st_r.core_q;
			st_nxt.rvalid = 1'b1;
		end
		if (i_req && (i_mode != BMD_MODE_NONE)) begin
			if (core_hit) begin
				if (i_wr) begin
					// core writes land whatever bank is active
					if (eff_off == `BMD_OFF_PCL)   st_nxt.program_counter_low   = i_wdata;
					if (eff_off == `BMD_OFF_FLAGS) st_nxt.flags = i_wdata;
					if (eff_off == `BMD_OFF_P0L)   st_nxt.p0l   = i_wdata;
					if (eff_off == `BMD_OFF_P0H)   st_nxt.p0h   = i_wdata;
					if (eff_off == `BMD_OFF_P1L)   st_nxt.p1l   = i_wdata;
					if (eff_off == `BMD_OFF_P1H)   st_nxt.p1h   = i_wdata;
					if (eff_off == `BMD_OFF_BANK)  st_nxt.bank  = i_wdata[5:0];
					if (eff_off == `BMD_OFF_ACC)   st_nxt.acc   = i_wdata;
					if (eff_off == `BMD_OFF_PCH)   st_nxt.pch   = i_wdata;
					if (eff_off == `BMD_OFF_INTC)  st_nxt.intc  = i_wdata;
				end else begin
					st_nxt.core_q  = core_rd;
					st_nxt.rd_core = 1'b1;
				end
			end else if (!i_wr) begin
				st_nxt.rd_mem = 1'b1;        // array answers next cycle
			end
		end
	end

	// state register
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r      <= '0;
			st_r.bank <= `BMD_BANK_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// array strobes, combinational
	assign o_mem_sel  = i_req && (i_mode != BMD_MODE_NONE) && !core_hit;
	assign o_mem_wr   = o_mem_sel && i_wr;
	assign o_mem_addr = addr;
	assign o_core_hit = i_req && core_hit;
	assign o_rdata    = st_r.rdata;
	assign o_rvalid   = st_r.rvalid;
	assign o_bank     = st_r.bank;

	// properties
	property p_bank_write;
		@(posedge i_clock) disable iff (!i_rst_b)
		(i_req && i_wr && i_mode == BMD_MODE_DIRECT && i_offset == `BMD_OFF_BANK)
			|=> (o_bank == $past(i_wdata[5:0]));
	endproperty
	a_bank_write: assert property (p_bank_write) else $error("bank write lost");

	property p_direct_addr;
		@(posedge i_clock) disable iff (!i_rst_b)
		(i_req && i_mode == BMD_MODE_DIRECT) |-> (o_mem_addr == {o_bank, i_offset});
	endproperty
	a_direct_addr: assert property (p_direct_addr) else $error("direct address bad");

	property p_core_no_mem;
		@(posedge i_clock) disable iff (!i_rst_b)
		(i_req && i_mode == BMD_MODE_DIRECT && i_offset <= `BMD_CORE_LAST) |-> !o_mem_sel;
	endproperty
	a_core_no_mem: assert property (p_core_no_mem) else $error("core hit reached array");

	property p_core_read;
		@(posedge i_clock) disable iff (!i_rst_b)
		(i_req && !i_wr && i_mode == BMD_MODE_DIRECT && i_offset == `BMD_OFF_ACC)
			|=> ##1 (o_rvalid && o_rdata == $past(st_r.acc, 2));
	endproperty
	a_core_read: assert property (p_core_read) else $error("core read wrong");

	property p_mem_read;
		@(posedge i_clock) disable iff (!i_rst_b)
		(o_mem_sel && !i_wr) |=> ##1 o_rvalid;
	endproperty
	a_mem_read: assert property (p_mem_read) else $error("array read not returned");

	property p_region_core;
		@(posedge i_clock) disable iff (!i_rst_b)
		o_core_hit |-> (o_region == BMD_REGION_CORE);
	endproperty
	a_region_core: assert property (p_region_core) else $error("region wrong");

	property p_bank_next;
		@(posedge i_clock) disable iff (!i_rst_b)
		(i_req && i_wr && i_mode == BMD_MODE_DIRECT && i_offset == `BMD_OFF_BANK)
			##1 (i_req && i_mode == BMD_MODE_DIRECT)
			|-> (o_mem_addr[12:7] == $past(i_wdata[5:0]));
	endproperty
	a_bank_next: assert property (p_bank_next) else $error("new bank not applied");

	property p_ptr0_addr;
		@(posedge i_clock) disable iff (!i_rst_b)
		(i_req && i_mode == BMD_MODE_PTR0) |-> (o_mem_addr[7:0] == st_r.p0l);
	endproperty
	a_ptr0_addr: assert property (p_ptr0_addr) else $error("pointer address bad");

	// a pointer that lands on the bank selector writes it like a direct access
	property p_ptr_core_write;
		@(posedge i_clock) disable iff (!i_rst_b)
		(i_req && i_wr && i_mode == BMD_MODE_PTR1 && o_mem_addr[6:0] == `BMD_OFF_BANK)
			|=> (o_bank == $past(i_wdata[5:0]));
	endproperty
	a_ptr_core_write: assert property (p_ptr_core_write) else $error("pointer core write lost");

	c_direct: cover property (@(posedge i_clock) o_mem_sel && i_mode == BMD_MODE_DIRECT);
	c_ptr1:   cover property (@(posedge i_clock) o_mem_sel && i_mode == BMD_MODE_PTR1);
	c_bank:   cover property (@(posedge i_clock) o_bank == 6'h3F);
	c_core:   cover property (@(posedge i_clock) o_core_hit && o_bank != 6'h00);
	c_ptrc:   cover property (@(posedge i_clock) o_core_hit && i_mode == BMD_MODE_PTR1);
endmodule : bmd_decoder

// >>> hw/bmd_pkg.sv
// types of the banked data memory decoder
package bmd_pkg;
	typedef logic [12:0] bmd_addr_t;   // full data memory address
	typedef logic [5:0]  bmd_bank_t;   // bank number
	typedef logic [6:0]  bmd_off_t;    // in-bank offset
	typedef logic [7:0]  bmd_byte_t;   // data byte
	// kind of location that an address lands on
	typedef enum logic [1:0] {
		BMD_REGION_CORE   = 2'b00,
		BMD_REGION_SFR    = 2'b01,
		BMD_REGION_GPR    = 2'b10,
		BMD_REGION_COMMON = 2'b11
	} bmd_region_t;
	// how the core reaches memory
	typedef enum logic [1:0] {
		BMD_MODE_DIRECT = 2'b00,
		BMD_MODE_PTR0   = 2'b01,
		BMD_MODE_PTR1   = 2'b10,
		BMD_MODE_NONE   = 2'b11
	} bmd_mode_t;
endpackage : bmd_pkg

// >>> hw/bmd_regs.svh
// register offsets, field positions and reset values of the banked data memory decoder
`ifndef BMD_REGS_SVH
`define BMD_REGS_SVH
`define BMD_NUM_BANKS       64
`define BMD_BANK_BYTES      128
`define BMD_CORE_COUNT      12
`define BMD_SFR_LIMIT       100
`define BMD_GPR_LIMIT       80
`define BMD_COMMON_BYTES    16
`define BMD_OFF_IND0        7'h00
`define BMD_OFF_IND1        7'h01
`define BMD_OFF_PCL         7'h02
`define BMD_OFF_FLAGS       7'h03
`define BMD_OFF_P0L         7'h04
`define BMD_OFF_P0H         7'h05
`define BMD_OFF_P1L         7'h06
`define BMD_OFF_P1H         7'h07
`define BMD_OFF_BANK        7'h08
`define BMD_OFF_ACC         7'h09
`define BMD_OFF_PCH         7'h0A
`define BMD_OFF_INTC        7'h0B
`define BMD_CORE_LAST       7'h0B
`define BMD_SFR_FIRST       7'h0C
`define BMD_GPR_FIRST       7'h20
`define BMD_COMMON_FIRST    7'h70
`define BMD_BANK_MSB        12
`define BMD_BANK_LSB        7
`define BMD_BANK_RST        6'h00
`define BMD_BYTE_RST        8'h00
`endif
